// ---- hw/asp_defines.vh ----
// Constants for the asynchronous serial port core
`ifndef ASP_DEFINES_VH
`define ASP_DEFINES_VH
`define ASP_DIV_RST 16'h0002
`define ASP_DIV_END 16'h0001
`define ASP_OVS_LAST 4'hf
`define ASP_MID_SAMPLE 4'h7
`define ASP_TO_CHARS 4
`define ASP_FIFO_DEPTH 16
`define ASP_PAR_ODD 2'h0
`define ASP_PAR_EVEN 2'h1
`define ASP_PAR_MARK 2'h2
`define ASP_PAR_SPACE 2'h3
`define ASP_LSR_DR 0
`define ASP_LSR_OE 1
`define ASP_LSR_PE 2
`define ASP_LSR_FE 3
`define ASP_LSR_BI 4
`define ASP_LSR_TX_HOLDING_EMPTY_FLAG 5
`define ASP_LSR_TEMT 6
`define ASP_LSR_ERR 7
`define ASP_MSR_DCTS 0
`define ASP_MSR_DDSR 1
`define ASP_MSR_TERI 2
`define ASP_MSR_DDCD 3
`define ASP_MSR_CTS 4
`define ASP_MSR_DSR 5
`define ASP_MSR_RI 6
`define ASP_MSR_DCD 7
`endif

// ---- hw/asp_core.v ----
// Asynchronous serial port core: FIFO, baud generator, transmitter, receiver, modem
`timescale 1ns/1ps
`include "asp_defines.vh"

module asp_fifo #(
    parameter W = 8,
    parameter D = 16,
    parameter AW = 4
) (
    input wire clk_sys,
    input wire rst,
    input wire in_valid,
    input wire [W-1:0] in_data,
    output reg in_ready,
    output reg out_valid,
    output wire [W-1:0] out_data,
    input wire out_ready,
    output reg [AW:0] count
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    wire [AW:0] cnt_nxt = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    assign out_data = mem[rd_ptr_r];

    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == D - 1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == D - 1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
            end
            count <= cnt_nxt;
            // Registered so back-pressure never forms a combinational path
            in_ready <= (cnt_nxt != D);
            out_valid <= (cnt_nxt != {(AW+1){1'b0}});
        end
    end
endmodule

module asp_core #(
    parameter DEPTH = `ASP_FIFO_DEPTH,
    parameter AW = 4
) (
    input wire clk_sys,
    input wire rst,
    input wire [15:0] divisor,
    input wire divisor_load,
    input wire [1:0] char_len,
    input wire stop_two,
    input wire parity_en,
    input wire [1:0] parity_sel,
    input wire fifo_en,
    input wire [AW:0] rx_trigger,
    input wire loop_en,
    input wire ie_rx,
    input wire ie_tx_holding_empty_flag,
    input wire ie_tc,
    input wire ie_ls,
    input wire ie_ms,
    input wire rts_ctl,
    input wire dtr_ctl,
    input wire tx_wr,
    input wire [7:0] tx_holding_reg,
    output reg tx_ready,
    input wire rx_rd,
    output reg [7:0] rx_buffer_reg,
    input wire lsr_rd,
    output reg [7:0] line_status_reg,
    input wire msr_rd,
    output reg [7:0] modem_status_reg,
    output reg irq,
    output reg txd,
    input wire rxd,
    output reg rts_n,
    output reg dtr_n,
    input wire cts_n,
    input wire dsr_n,
    input wire ri_n,
    input wire dcd_n
);
    localparam TX_IDLE = 3'h0;
    localparam TX_START = 3'h1;
    localparam TX_DATA = 3'h2;
    localparam TX_PAR = 3'h3;
    localparam TX_STOP = 3'h4;
    localparam RX_IDLE = 2'h0;
    localparam RX_START = 2'h1;
    localparam RX_DATA = 2'h2;
    localparam RX_END = 2'h3;

    // Parity of the valid data bits for the selected mode
    function par_bit;
        input [7:0] d;
        input [1:0] sel;
        begin
            case (sel)
                `ASP_PAR_ODD: par_bit = ~(^d);
                `ASP_PAR_EVEN: par_bit = ^d;
                `ASP_PAR_MARK: par_bit = 1'b1;
                default: par_bit = 1'b0;
            endcase
        end
    endfunction

    function [7:0] len_mask;
        input [1:0] len;
        begin
            len_mask = 8'hff >> (2'h3 - len);
        end
    endfunction

    // Five to eight data bits; nine is eight plus forced parity
    wire [2:0] last_idx = {1'b0, char_len} + 3'h4;

    // Pin synchronisers: five inputs through three flops each
    wire [4:0] pin_in = {dcd_n, ri_n, dsr_n, cts_n, rxd};
    reg [4:0] pin_filt_r;
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
            reg s1_r;
            reg s2_r;
            reg s3_r;
            always @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    s1_r <= 1'b1;
                    s2_r <= 1'b1;
                    s3_r <= 1'b1;
                    pin_filt_r[gi] <= 1'b1;
                end else begin
                    s1_r <= pin_in[gi];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r) begin
                        pin_filt_r[gi] <= s3_r;
                    end
                end
            end
        end
    endgenerate

    reg [15:0] brg_cnt_r;
    reg btick_r;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            brg_cnt_r <= `ASP_DIV_RST;
            btick_r <= 1'b0;
        end else if (divisor_load) begin
            brg_cnt_r <= divisor;
            btick_r <= 1'b0;
        end else if (brg_cnt_r <= `ASP_DIV_END) begin
            brg_cnt_r <= divisor;
            btick_r <= 1'b1;
        end else begin
            brg_cnt_r <= brg_cnt_r - 16'h0001;
            btick_r <= 1'b0;
        end
    end

    // Transmit FIFO, write only from the processor side
    wire txf_in_ready;
    wire txf_valid;
    wire [7:0] txf_data;
    wire [AW:0] txf_count;
    reg txf_pop;
    wire tx_accept = tx_wr & tx_ready;
    asp_fifo #(.W(8), .D(DEPTH), .AW(AW)) u_txf (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(tx_accept),
        .in_data(tx_holding_reg),
        .in_ready(txf_in_ready),
        .out_valid(txf_valid),
        .out_data(txf_data),
        .out_ready(txf_pop),
        .count(txf_count)
    );

    reg [2:0] tx_st_r;
    reg [3:0] tx_sub_r;
    reg [2:0] tx_idx_r;
    reg [7:0] tx_sh_r;
    reg tx_par_r;
    reg tx_stop2_r;
    reg tx_line_r;
    reg tc_flag_r;
    wire tx_bit_end = btick_r & (tx_sub_r == `ASP_OVS_LAST);
    wire tx_holding_empty_flag = ~txf_valid;
    wire temt = tx_holding_empty_flag & (tx_st_r == TX_IDLE);

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_st_r <= TX_IDLE;
            tx_sub_r <= 4'h0;
            tx_idx_r <= 3'h0;
            tx_sh_r <= 8'h00;
            tx_par_r <= 1'b0;
            tx_stop2_r <= 1'b0;
            tx_line_r <= 1'b1;
            tc_flag_r <= 1'b0;
            txf_pop <= 1'b0;
        end else begin
            txf_pop <= 1'b0;
            if (btick_r) begin
                tx_sub_r <= tx_sub_r + 4'h1;
            end
            // Completion flag cleared by a write unless set this cycle
            if (tx_accept) begin
                tc_flag_r <= 1'b0;
            end
            case (tx_st_r)
                TX_IDLE: begin
                    tx_line_r <= 1'b1;
                    if (txf_valid & ~txf_pop) begin
                        txf_pop <= 1'b1;
                        tx_sh_r <= txf_data & len_mask(char_len);
                        tx_par_r <= par_bit(txf_data & len_mask(char_len), parity_sel);
                        tx_stop2_r <= stop_two;
                        tx_sub_r <= 4'h0;
                        tx_line_r <= 1'b0;
                        tx_st_r <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_bit_end) begin
                        tx_line_r <= tx_sh_r[0];
                        tx_idx_r <= 3'h0;
                        tx_st_r <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_bit_end) begin
                        tx_sh_r <= {1'b0, tx_sh_r[7:1]};
                        tx_idx_r <= tx_idx_r + 3'h1;
                        if (tx_idx_r == last_idx) begin
                            tx_line_r <= parity_en ? tx_par_r : 1'b1;
                            tx_st_r <= parity_en ? TX_PAR : TX_STOP;
                        end else begin
                            tx_line_r <= tx_sh_r[1];
                        end
                    end
                end
                TX_PAR: begin
                    if (tx_bit_end) begin
                        tx_line_r <= 1'b1;
                        tx_st_r <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    if (tx_bit_end) begin
                        if (tx_stop2_r) begin
                            tx_stop2_r <= 1'b0;
                        end else begin
                            tx_st_r <= TX_IDLE;
                            if (~txf_valid) begin
                                tc_flag_r <= 1'b1;
                            end
                        end
                    end
                end
                default: tx_st_r <= TX_IDLE;
            endcase
        end
    end

    // Loopback feeds transmit data back and isolates the pins
    wire rx_line = loop_en ? tx_line_r : pin_filt_r[0];
    wire [3:0] modem_in = loop_en ? {1'b0, 1'b0, dtr_ctl, rts_ctl} : ~pin_filt_r[4:1];

    // Receive FIFO carries break, framing and parity status with each byte
    reg rxf_push;
    reg [10:0] rxf_wdata;
    wire rxf_in_ready;
    wire rxf_valid;
    wire [10:0] rxf_head;
    wire [AW:0] rxf_count;
    wire rx_pop = rx_rd & rxf_valid;
    asp_fifo #(.W(11), .D(DEPTH), .AW(AW)) u_rxf (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(rxf_push),
        .in_data(rxf_wdata),
        .in_ready(rxf_in_ready),
        .out_valid(rxf_valid),
        .out_data(rxf_head),
        .out_ready(rx_pop),
        .count(rxf_count)
    );
    wire rx_room = fifo_en ? rxf_in_ready : ~rxf_valid;

    reg [1:0] rx_st_r;
    reg [3:0] rx_sub_r;
    // Spare index bit so the parity slot after an 8-bit character is reachable
    reg [3:0] rx_idx_r;
    wire [3:0] rx_last = {1'b0, last_idx};
    reg [7:0] rx_sh_r;
    reg rx_par_r;
    reg rx_prev_r;
    reg oe_r;
    wire rx_mid = btick_r & (rx_sub_r == `ASP_MID_SAMPLE);
    wire rx_end = btick_r & (rx_sub_r == `ASP_OVS_LAST);
    wire rx_pe = parity_en & (rx_par_r != par_bit(rx_sh_r, parity_sel));
    wire rx_bi = (rx_sh_r == 8'h00) & ~rx_line & ~(parity_en & rx_par_r);

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_st_r <= RX_IDLE;
            rx_sub_r <= 4'h0;
            rx_idx_r <= 4'h0;
            rx_sh_r <= 8'h00;
            rx_par_r <= 1'b0;
            rx_prev_r <= 1'b1;
            rxf_push <= 1'b0;
            rxf_wdata <= 11'h000;
            oe_r <= 1'b0;
        end else begin
            rxf_push <= 1'b0;
            rx_prev_r <= rx_line;
            if (btick_r) begin
                rx_sub_r <= rx_sub_r + 4'h1;
            end
            // Overrun is cleared by a status read; a new overrun wins
            if (lsr_rd) begin
                oe_r <= 1'b0;
            end
            case (rx_st_r)
                RX_IDLE: begin
                    // Align to the falling edge of the start bit
                    if (rx_prev_r & ~rx_line) begin
                        rx_sub_r <= 4'h0;
                        rx_sh_r <= 8'h00;
                        rx_idx_r <= 4'h0;
                        rx_st_r <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_mid & rx_line) begin
                        rx_st_r <= RX_IDLE;
                    end else if (rx_end) begin
                        rx_st_r <= RX_DATA;
                    end
                end
                RX_DATA: begin
                    // Bits stored by index so unused upper bits stay zero
                    if (rx_mid) begin
                        if (rx_idx_r > rx_last) begin
                            rx_par_r <= rx_line;
                        end else begin
                            rx_sh_r[rx_idx_r[2:0]] <= rx_line;
                        end
                    end else if (rx_end) begin
                        if (rx_idx_r == rx_last && !parity_en) begin
                            rx_st_r <= RX_END;
                        end else if (rx_idx_r > rx_last) begin
                            rx_st_r <= RX_END;
                        end
                        rx_idx_r <= rx_idx_r + 4'h1;
                    end
                end
                RX_END: begin
                    // Parity, framing, break and overrun capture
                    // A mark byte under space check lands as a parity error
                    if (rx_mid) begin
                        rx_st_r <= RX_IDLE;
                        if (rx_room) begin
                            rxf_push <= 1'b1;
                            rxf_wdata <= {rx_bi, ~rx_line, rx_pe, rx_sh_r};
                        end else begin
                            oe_r <= 1'b1;
                        end
                    end
                end
                default: rx_st_r <= RX_IDLE;
            endcase
        end
    end

    // Error summary, time-out and line status acknowledge
    reg [AW:0] err_cnt_r;
    reg ls_ack_r;
    reg [9:0] to_cnt_r;
    reg to_flag_r;
    wire head_err = rxf_valid & (|rxf_head[10:8]);
    wire push_err = rxf_push & (|rxf_wdata[10:8]);
    wire [3:0] frame_bits = {2'h0, char_len} + 4'h7 + {3'h0, parity_en} + {3'h0, stop_two};
    wire [9:0] to_limit = {frame_bits, 6'h00};

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            err_cnt_r <= {(AW+1){1'b0}};
            ls_ack_r <= 1'b0;
            to_cnt_r <= 10'h000;
            to_flag_r <= 1'b0;
        end else begin
            // Count errored bytes held in the FIFO
            err_cnt_r <= err_cnt_r + {{AW{1'b0}}, push_err} - {{AW{1'b0}}, rx_pop & head_err};
            // Status read clears until a new byte reaches the head
            if (rx_pop) begin
                ls_ack_r <= 1'b0;
            end else if (lsr_rd) begin
                ls_ack_r <= 1'b1;
            end
            // Four idle character times below the trigger level
            if (rxf_push | rx_pop | ~rxf_valid) begin
                to_cnt_r <= 10'h000;
            end else if (btick_r & (to_cnt_r != to_limit)) begin
                to_cnt_r <= to_cnt_r + 10'h001;
            end
            if (~rxf_valid) begin
                to_flag_r <= 1'b0;
            end else if (fifo_en & (to_cnt_r == to_limit) & (rxf_count < rx_trigger)) begin
                to_flag_r <= 1'b1;
            end
        end
    end

    // Modem status deltas; ring only on its trailing edge
    reg [3:0] mdm_prev_r;
    reg [3:0] mdm_delta_r;
    wire [3:0] mdm_chg = modem_in ^ mdm_prev_r;
    wire [3:0] mdm_evt = {mdm_chg[3], mdm_chg[2] & ~modem_in[2], mdm_chg[1:0]};
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mdm_prev_r <= 4'h0;
            mdm_delta_r <= 4'h0;
        end else begin
            mdm_prev_r <= modem_in;
            // Read clears, a change in the same cycle wins
            mdm_delta_r <= (msr_rd ? 4'h0 : mdm_delta_r) | mdm_evt;
        end
    end

    wire dr_int = fifo_en ? (rxf_count >= rx_trigger) & rxf_valid : rxf_valid;
    // Line status raised while the errored byte is at the head, or while overrun is set
    wire ls_int = (head_err & ~ls_ack_r) | oe_r;
    // One enable for data-ready and time-out
    wire rx_int = ie_rx & (dr_int | to_flag_r);
    // Empty holding register raises its interrupt from reset on
    wire tx_int = (ie_tx_holding_empty_flag & tx_holding_empty_flag) | (ie_tc & tc_flag_r);

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
            txd <= 1'b1;
            rts_n <= 1'b1;
            dtr_n <= 1'b1;
            tx_ready <= 1'b1;
            rx_buffer_reg <= 8'h00;
            line_status_reg <= 8'h60;
            modem_status_reg <= 8'h00;
        end else begin
            irq <= rx_int | tx_int | (ie_ls & ls_int) | (ie_ms & (|mdm_delta_r));
            txd <= loop_en ? 1'b1 : tx_line_r;
            rts_n <= loop_en ? 1'b1 : ~rts_ctl;
            dtr_n <= loop_en ? 1'b1 : ~dtr_ctl;
            tx_ready <= fifo_en ? txf_in_ready : (txf_count == {(AW+1){1'b0}});
            // Read returns the head byte and drops it
            if (rx_pop) begin
                rx_buffer_reg <= rxf_head[7:0];
            end
            line_status_reg <= {err_cnt_r != {(AW+1){1'b0}}, temt, tx_holding_empty_flag,
                rxf_head[10] & rxf_valid, rxf_head[9] & rxf_valid,
                rxf_head[8] & rxf_valid, oe_r, rxf_valid};
            modem_status_reg <= {modem_in[3], modem_in[2], modem_in[1], modem_in[0],
                mdm_delta_r};
        end
    end
endmodule

// ---- test/asp_core_monitor.sv ----
// Assertion checker bound to the serial port core
`timescale 1ns/1ps
module asp_core_monitor (
    input wire clk_sys,
    input wire rst,
    input wire loop_en,
    input wire rts_ctl,
    input wire [1:0] char_len,
    input wire ie_rx,
    input wire ie_tx_holding_empty_flag,
    input wire ie_tc,
    input wire ie_ls,
    input wire ie_ms,
    input wire rx_rd,
    input wire [7:0] rx_buffer_reg,
    input wire [7:0] line_status_reg,
    input wire [7:0] modem_status_reg,
    input wire irq,
    input wire txd,
    input wire rts_n,
    input wire dtr_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire ie_any = ie_rx | ie_tx_holding_empty_flag | ie_tc | ie_ls | ie_ms;
    reset_empty_flags_a: assert property ($fell(rst) |-> line_status_reg[6:5] == 2'h3)
        else $error("holding and shift empty flags not set after reset");
    // Any bit lasts 16 ticks of at least one cycle each
    start_bit_len_a: assert property ($fell(txd) |-> !txd [*8])
        else $error("low level on txd shorter than a bit");
    loop_quiet_a: assert property (loop_en && $past(loop_en) |-> txd && rts_n && dtr_n)
        else $error("line outputs active during loopback");
    rts_follow_a: assert property (!$past(loop_en) && !$past(rst) |->
        rts_n == !$past(rts_ctl))
        else $error("rts_n does not follow its control");
    irq_gate_a: assert property (!ie_any && !$past(ie_any) |-> !irq)
        else $error("interrupt raised with every source disabled");
    rx_hold_a: assert property ($changed(rx_buffer_reg) |-> $past(rx_rd))
        else $error("receive buffer changed without a read");
    short_char_a: assert property (rx_rd && line_status_reg[0] && char_len == 2'h0 |=>
        rx_buffer_reg[7:5] == 3'h0)
        else $error("unused upper bits of a short character not zero");
    ms_irq_a: assert property (ie_ms && modem_status_reg[3:0] != 4'h0 |-> ##[0:2] irq)
        else $error("modem change did not raise the interrupt");
    cover property ($fell(txd));
    cover property ($rose(line_status_reg[0]));
    cover property ($rose(irq));
endmodule
bind asp_core asp_core_monitor asp_core_monitor_inst (.clk_sys(clk_sys), .rst(rst),
    .loop_en(loop_en), .rts_ctl(rts_ctl), .char_len(char_len), .ie_rx(ie_rx),
    .ie_tx_holding_empty_flag(ie_tx_holding_empty_flag), .ie_tc(ie_tc), .ie_ls(ie_ls), .ie_ms(ie_ms), .rx_rd(rx_rd),
    .rx_buffer_reg(rx_buffer_reg), .line_status_reg(line_status_reg),
    .modem_status_reg(modem_status_reg), .irq(irq), .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n));

// ---- test/asp_line_model.sv ----
// Remote serial device on the far end of the line
`timescale 1ns/1ps
module asp_line_model #(
    parameter int BIT = 32
) (
    input wire clk_sys,
    input wire txd,
    output logic rxd
);
    logic [9:0] got_q[$];
    logic [9:0] sh;
    initial rxd = 1'h1;
    // caller composes data, parity and stop bits
    task automatic send(input logic [11:0] f, input int n);
        rxd <= 1'h0;
        repeat (BIT) @(posedge clk_sys);
        for (int i = 0; i < n; i++) begin
            rxd <= f[i];
            repeat (BIT) @(posedge clk_sys);
        end
        rxd <= 1'h1;
    endtask
    // Ten samples cover eight data bits plus parity or a second stop
    initial forever begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge clk_sys);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT) @(posedge clk_sys);
            sh[i] = txd;
        end
        got_q.push_back(sh);
    end
endmodule

// ---- test/asp_core_bench.sv ----
// Self-checking bench for the serial port core
`timescale 1ns/1ps
module asp_core_bench;
    localparam int BIT = 32;
    logic clk_sys = 1'h0, rst = 1'h1, divisor_load = 1'h0, stop_two = 1'h0, parity_en = 1'h0;
    logic fifo_en = 1'h0, loop_en = 1'h0, ie_rx = 1'h0, ie_tx_holding_empty_flag = 1'h1, ie_tc = 1'h0;
    logic ie_ls = 1'h0, ie_ms = 1'h0, rts_ctl = 1'h0, dtr_ctl = 1'h0;
    logic cts_n = 1'h1, dsr_n = 1'h1, ri_n = 1'h1, dcd_n = 1'h1;
    logic [3:0] stb = 4'h0;
    logic [15:0] divisor = 16'h0002;
    logic [1:0] char_len = 2'h3, parity_sel = 2'h0;
    logic [4:0] rx_trigger = 5'h01;
    logic [7:0] tx_holding_reg = 8'h00;
    logic [9:0] ef[3] = '{10'h342, 10'h055, 10'h000};
    logic [7:0] el[3] = '{8'he5, 8'he9, 8'hf9};
    wire tx_ready, irq, txd, rxd, rts_n, dtr_n;
    wire [7:0] rx_buffer_reg, line_status_reg, modem_status_reg;
    int n_errors = 0, n_compared = 0, k;
    always #5 clk_sys = ~clk_sys;
    asp_core asp_core_inst (.clk_sys(clk_sys), .rst(rst), .divisor(divisor),
        .divisor_load(divisor_load), .char_len(char_len), .stop_two(stop_two),
        .parity_en(parity_en), .parity_sel(parity_sel), .fifo_en(fifo_en),
        .rx_trigger(rx_trigger), .loop_en(loop_en), .ie_rx(ie_rx), .ie_tx_holding_empty_flag(ie_tx_holding_empty_flag),
        .ie_tc(ie_tc), .ie_ls(ie_ls), .ie_ms(ie_ms), .rts_ctl(rts_ctl), .dtr_ctl(dtr_ctl),
        .tx_wr(stb[0]), .tx_holding_reg(tx_holding_reg), .tx_ready(tx_ready),
        .rx_rd(stb[1]), .rx_buffer_reg(rx_buffer_reg), .lsr_rd(stb[2]),
        .line_status_reg(line_status_reg), .msr_rd(stb[3]),
        .modem_status_reg(modem_status_reg), .irq(irq), .txd(txd), .rxd(rxd),
        .rts_n(rts_n), .dtr_n(dtr_n), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
        .dcd_n(dcd_n));
    asp_line_model #(.BIT(BIT)) asp_line_model_inst (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Strobe mask: bit 0 write, 1 read, 2 status read, 3 modem read
    task automatic pulse(input logic [3:0] m);
        stb <= m;
        cyc(1);
        stb <= 4'h0;
        cyc(3);
    endtask
    task automatic wr(input logic [7:0] d);
        tx_holding_reg <= d;
        pulse(4'h1);
    endtask
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [9:0] got();
        return asp_line_model_inst.got_q.pop_front();
    endfunction
    task test_done;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        cyc(40000);
        n_errors++;
        test_done;
    end
    initial begin
        cyc(8);
        rst <= 1'h0;
        cyc(2);
        chk("lsr", 10'h060, line_status_reg);
        chk("irq", 10'h001, irq);
        chk("txd", 10'h001, txd);
        {ie_tx_holding_empty_flag, ie_tc, parity_en} <= 3'h3;
        for (int s = 0; s < 4; s++) begin
            parity_sel <= s[1:0];
            wr(8'h03);
            chk("irq", 10'h000, irq);
            cyc(12 * BIT);
            chk("irq", 10'h001, irq);
            chk("frame", {1'h1, ~s[0], 8'h03}, got());
        end
        {ie_tc, parity_en, stop_two, fifo_en} <= 4'h3;
        k = 0;
        // Sixteen queued plus one already shifting out
        for (int i = 0; i < 20; i++)
            if (tx_ready === 1'h1) begin
                wr(i[7:0]);
                k++;
            end else
                cyc(1);
        wr(8'hee);
        chk("accepted", 10'd17, k[9:0]);
        cyc(17 * 12 * BIT);
        for (int i = 0; i < 17; i++)
            chk("fifo frame", {2'h3, i[7:0]}, got());
        chk("extra", 10'h000, asp_line_model_inst.got_q.size());
        {fifo_en, stop_two, parity_en, ie_rx} <= 4'h3;
        parity_sel <= 2'h3;
        asp_line_model_inst.send({2'h2, 8'h3c}, 10);
        cyc(4);
        chk("dr irq", 10'h001, irq);
        pulse(4'h2);
        chk("rx", 10'h03c, rx_buffer_reg);
        chk("lsr", 10'h060, line_status_reg);
        chk("irq", 10'h000, irq);
        {ie_rx, ie_ls} <= 2'h1;
        for (int e = 0; e < 3; e++) begin
            asp_line_model_inst.send(ef[e], 10);
            cyc(4);
            chk("lsr err", el[e], line_status_reg);
            chk("ls irq", 10'h001, irq);
            pulse(4'h4);
            chk("ls irq", 10'h000, irq);
            pulse(4'h2);
            chk("lsr", 10'h060, line_status_reg);
        end
        {char_len, parity_en} <= 3'h0;
        asp_line_model_inst.send({1'h1, 5'h15}, 6);
        cyc(4);
        pulse(4'h2);
        chk("rx5", 10'h015, rx_buffer_reg);
        {char_len, fifo_en, ie_rx, ie_ls} <= 5'h1e;
        rx_trigger <= 5'h04;
        asp_line_model_inst.send({1'h1, 8'h99}, 9);
        cyc(4);
        chk("to early", 10'h000, irq);
        cyc(1300);
        chk("to irq", 10'h001, irq);
        pulse(4'h2);
        chk("rx", 10'h099, rx_buffer_reg);
        chk("to clr", 10'h000, irq);
        {ie_rx, ie_ms} <= 2'h1;
        cts_n <= 1'h0;
        // Three synchroniser stages, then the delta and the status register
        cyc(7);
        chk("msr", 10'h011, modem_status_reg);
        chk("ms irq", 10'h001, irq);
        pulse(4'h8);
        chk("msr", 10'h010, modem_status_reg);
        ri_n <= 1'h0;
        cyc(7);
        chk("msr", 10'h050, modem_status_reg);
        chk("ms irq", 10'h000, irq);
        ri_n <= 1'h1;
        cyc(7);
        chk("msr", 10'h014, modem_status_reg);
        {rts_ctl, dtr_ctl} <= 2'h3;
        cyc(3);
        chk("ctl", 10'h000, {rts_n, dtr_n});
        {ie_ms, loop_en, fifo_en} <= 3'h2;
        // Slower divisor exercises the reload path of the baud counter
        divisor <= 16'h0003;
        divisor_load <= 1'h1;
        cyc(1);
        divisor_load <= 1'h0;
        wr(8'hc6);
        cyc(18 * BIT);
        pulse(4'h2);
        chk("loop", 10'h0c6, rx_buffer_reg);
        test_done;
    end
endmodule
